/* File: shared/rkp_pkg.sv */
// constants, register map and helper functions for the remote-control port block
//
// Summary of operation
// - direction bit 1 makes pin output, 0 input; A, B, D directions reset zero.
// - output pins drive stored data; reads of such bits return the stored value.
// - pull-up is forced off on any pin in output mode.
// - input pins read the pin level; pull-up follows its enable bit.
// - port A bit 3 is input only, read-only, with pull-up and edge wake.
// - in halt, an edge on a wake-enabled pin restarts clock, jumps to 04H.
// - wake enable bit 1 allows edge wake for that pin; resets to zero.
// - system reset combines power-on, low voltage, reset pin and watchdog overflow.
// - reset pin asserted during halt returns the device to normal mode.
// - low-voltage reset is on from power-up and off during halt.
// - halt stops the clock; only wake edges, the reset pin, power-on or watchdog overflow restart it.
// - wait 128 core cycles after oscillator start, at power-on and at wake.
// - clock option picks 250k/1M/2M/4M from RC, or crystal over 16/8/4/2.
// - crystal option 0 gives PB0/PB1 to the crystal; 1 keeps them I/O.
// - IR divider code 000 makes IR pin follow control bit 3.
// - IR codes 001-111 divide IR clock with the tabled periods and duties.
// - IR clock is fast RC over 8, or crystal directly in crystal mode.
// - IR pin is open drain, sink only, carrying the carrier.
// - port C control: bit0 data, bit1 direction, bit2 wake, bit3 pull-up.
// - halt key scan drives one low pulse per pin, PA2..PA0, PB, PD, PC0.
// - key scan runs from a 20 kHz clock with fixed 2.4 ms period.
// - key scan needs its option; wake-disabled pins are skipped and left alone.
package rkp_pkg;
    localparam int REF_HZ = 25_000_000;

    // main space addresses
    localparam logic [4:0] ADR_PA_DIR = 5'h02;
    localparam logic [4:0] ADR_PA_DAT = 5'h03;
    localparam logic [4:0] ADR_PC_CTL = 5'h04;
    localparam logic [4:0] ADR_PB_DIR = 5'h05;
    localparam logic [4:0] ADR_PB_DAT = 5'h06;
    localparam logic [4:0] ADR_PD_DIR = 5'h0c;
    localparam logic [4:0] ADR_PD_DAT = 5'h0d;
    localparam logic [4:0] ADR_IR_CTL = 5'h13;
    // extended space addresses
    localparam logic [3:0] XADR_PA_PU = 4'h0;
    localparam logic [3:0] XADR_PB_PU = 4'h2;
    localparam logic [3:0] XADR_PD_PU = 4'h4;
    localparam logic [3:0] XADR_PA_WK = 4'h6;
    localparam logic [3:0] XADR_PB_WK = 4'h7;
    localparam logic [3:0] XADR_PD_WK = 4'h8;

    localparam logic [3:0] REG_RST = 4'h0;
    // port C and IR control field positions
    localparam int PC_DAT_BIT = 0;
    localparam int PC_DIR_BIT = 1;
    localparam int PC_WK_BIT = 2;
    localparam int PC_PU_BIT = 3;
    localparam int IR_STATIC_BIT = 3;

    localparam logic [10:0] WAKE_VECTOR = 11'h004;
    localparam int STABLE_CORE_CYCLES = 128;

    // core clock rates
    localparam int CORE_RC_HZ [4] = '{250_000, 1_000_000, 2_000_000, 4_000_000};
    localparam int XTAL_HZ = 4_000_000;
    localparam int XTAL_DIV [4] = '{16, 8, 4, 2};
    localparam int CORE_CYC_RC [4] = '{REF_HZ / CORE_RC_HZ[0], REF_HZ / CORE_RC_HZ[1],
                                       REF_HZ / CORE_RC_HZ[2], REF_HZ / CORE_RC_HZ[3]};
    localparam int CORE_CYC_XT [4] = '{REF_HZ / (XTAL_HZ / XTAL_DIV[0]),
                                       REF_HZ / (XTAL_HZ / XTAL_DIV[1]),
                                       REF_HZ / (XTAL_HZ / XTAL_DIV[2]),
                                       REF_HZ / (XTAL_HZ / XTAL_DIV[3])};

    // IR carrier clock
    localparam int IR_RC_HZ = 32_000_000;
    localparam int IR_RC_DIV = 8;
    localparam int IR_CYC_RC = REF_HZ / (IR_RC_HZ / IR_RC_DIV);
    localparam int IR_CYC_XT = REF_HZ / XTAL_HZ;
    // carrier period and low count per code
    localparam logic [6:0] IR_PERIOD [8] = '{7'h01, 7'h69, 7'h69, 7'h46,
                                             7'h47, 7'h5f, 7'h64, 7'h6f};
    localparam logic [6:0] IR_LOW [8] = '{7'h00, 7'h34, 7'h23, 7'h23,
                                          7'h17, 7'h1f, 7'h21, 7'h25};

    // key scan timing
    localparam int KS_CLK_HZ = 20_000;
    localparam int KS_TICK_CYC = REF_HZ / KS_CLK_HZ;
    localparam int SCAN_PERIOD_US = 2400;
    localparam int SCAN_TICKS = SCAN_PERIOD_US * KS_CLK_HZ / 1_000_000;
    localparam int SCAN_SLOTS = 16;
    localparam int SLOT_TICKS = SCAN_TICKS / SCAN_SLOTS;
    localparam int SCAN_PINS = 12;

    typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_STABLE} rkp_state_e;

    function automatic logic [7:0] core_div_cyc(input logic [1:0] sel, input logic xtal_n);
        core_div_cyc = xtal_n ? 8'(CORE_CYC_RC[sel]) : 8'(CORE_CYC_XT[sel]);
    endfunction

    // pins in scan order, PA2 at index 11, PC0 at 0
    function automatic logic [11:0] scan_vec(input logic [3:0] a, input logic [3:0] b,
                                             input logic [3:0] d, input logic c);
        scan_vec = {a[2], a[1], a[0], b[3], b[2], b[1], b[0], d[3], d[2], d[1], d[0], c};
    endfunction

    function automatic logic [3:0] rd_mix(input logic [3:0] dir, input logic [3:0] dat,
                                          input logic [3:0] pin);
        rd_mix = (dir & dat) | (~dir & pin);
    endfunction
endpackage

/* File: hw/rkp_ir_gen.sv */
// IR carrier generator with selectable period and duty
`timescale 1ns/100ps
module rkp_ir_gen
    import rkp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [2:0] code_i,
    input wire logic static_i,
    output logic level_o
);
    logic [6:0] cnt_ff;
    logic level_ff;
    logic [6:0] period;
    logic [6:0] low;

    assign period = IR_PERIOD[code_i];
    assign low = IR_LOW[code_i];
    assign level_o = level_ff;

    // ****************************************
    // period counter
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || code_i == 3'h0) begin
            cnt_ff <= 7'h00;
        end else if (tick_i) begin
            // a code change may leave cnt past the new period
            cnt_ff <= (cnt_ff >= period - 7'h01) ? 7'h00 : cnt_ff + 7'h01;
        end
    end

    // ****************************************
    // output level, low part first
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            level_ff <= 1'b1;
        end else if (code_i == 3'h0) begin
            level_ff <= static_i;
        end else begin
            level_ff <= (cnt_ff < low) ? 1'b0 : 1'b1;
        end
    end
endmodule

/* File: hw/rkp_ports.sv */
// remote-control I/O ports with halt wake-up, key scan and IR carrier output
`timescale 1ns/100ps
module rkp_ports
    import rkp_pkg::*;
#(
    parameter int STABLE_CYCLES = STABLE_CORE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_ext_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_wdata_i,
    output logic [3:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic [3:0] pa_in_i,
    output logic [3:0] pa_out_o,
    output logic [3:0] pa_oe_o,
    output logic [3:0] pa_pu_o,
    input wire logic [3:0] pb_in_i,
    output logic [3:0] pb_out_o,
    output logic [3:0] pb_oe_o,
    output logic [3:0] pb_pu_o,
    input wire logic [3:0] pd_in_i,
    output logic [3:0] pd_out_o,
    output logic [3:0] pd_oe_o,
    output logic [3:0] pd_pu_o,
    input wire logic pc_in_i,
    output logic pc_out_o,
    output logic pc_oe_o,
    output logic pc_pu_o,
    output logic ir_led_output_pin_o,
    output logic ir_led_output_pin_oe_o,
    input wire logic key_scan_option_i,
    input wire logic crystal_mode_option_n_i,
    input wire logic core_clock_select_hi_i,
    input wire logic core_clock_select_lo_i,
    input wire logic shared_reset_pin_option_i,
    input wire logic por_i,
    input wire logic lv_detect_i,
    input wire logic wdt_overflow_i,
    input wire logic halt_req_i,
    output logic sys_reset_o,
    output logic low_voltage_reset_en_o,
    output logic osc_run_o,
    output logic crystal_osc_en_o,
    output logic core_clk_en_o,
    output logic core_run_o,
    output logic pc_load_o,
    output logic [10:0] pc_load_addr_o
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (STABLE_CYCLES < 1 || STABLE_CYCLES > 255) begin : g_chk
        $error("STABLE_CYCLES must be 1..255");
    end

    localparam logic [7:0] STABLE_LAST = 8'(STABLE_CYCLES - 1);
    localparam logic [10:0] KS_LAST = 11'(KS_TICK_CYC - 1);
    localparam logic [1:0] SUB_LAST = 2'(SLOT_TICKS - 1);
    localparam logic [3:0] SLOT_LAST = 4'(SCAN_SLOTS - 1);
    localparam logic [3:0] SLOT_PINS = 4'(SCAN_PINS);
    localparam logic [2:0] IR_LAST_RC = 3'(IR_CYC_RC - 1);
    localparam logic [2:0] IR_LAST_XT = 3'(IR_CYC_XT - 1);

    logic blk_rst;
    logic sys_reset_ff;
    logic lv_en_ff;
    rkp_state_e state_ff;
    logic [7:0] stable_cnt_ff;
    logic [7:0] core_cnt_ff;
    logic core_tick_ff;
    logic [2:0] ir_cnt_ff;
    logic ir_tick_ff;
    logic ir_level;
    logic pc_load_ff;
    logic [3:0] pa_dir_ff, pb_dir_ff, pd_dir_ff;
    logic [2:0] pa_dat_ff;
    logic [3:0] pb_dat_ff, pd_dat_ff;
    logic [3:0] pc_ctl_ff;
    logic [3:0] ir_ctl_ff;
    logic [3:0] pa_pu_ff, pb_pu_ff, pd_pu_ff;
    logic [3:0] pa_wk_ff, pb_wk_ff, pd_wk_ff;
    logic [3:0] rdata_ff;
    logic rvalid_ff;
    logic [10:0] ks_cnt_ff;
    logic [1:0] sub_ff;
    logic [3:0] slot_ff;
    logic [11:0] drive_ff, drive_prev_ff;
    logic [12:0] prev_ff;
    logic ext_reset;
    logic scanning;
    logic ks_tick;
    logic wake;
    logic wr_main, wr_ext;
    logic xtal_mode;
    logic pa3_io;
    logic [11:0] dir_v, dat_v, pu_v, wk_v, xmask_v;
    logic [11:0] oe_v, out_v, pul_v, scan_v;
    logic [12:0] lvl_v, wke_v, edge_v;

    assign xtal_mode = ~crystal_mode_option_n_i;
    assign pa3_io = shared_reset_pin_option_i;

    // ****************************************
    // system reset and low-voltage gating
    // ****************************************
    assign ext_reset = ~pa3_io & ~pa_in_i[3];

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sys_reset_ff <= 1'b1;
        end else begin
            sys_reset_ff <= por_i | (lv_detect_i & lv_en_ff) | ext_reset | wdt_overflow_i;
        end
    end

    assign blk_rst = rst_i | sys_reset_ff;

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            lv_en_ff <= 1'b1;
        end else begin
            lv_en_ff <= (state_ff != ST_HALT);
        end
    end

    // ****************************************
    // halt, wake and start-up sequencing
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            // reset, also from halt, restarts through the stable delay
            state_ff <= ST_STABLE;
        end else begin
            unique case (state_ff)
                ST_RUN: begin
                    if (halt_req_i) begin
                        state_ff <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (wake) begin
                        state_ff <= ST_STABLE;
                    end
                end
                ST_STABLE: begin
                    if (core_tick_ff && stable_cnt_ff == STABLE_LAST) begin
                        state_ff <= ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst || state_ff != ST_STABLE) begin
            stable_cnt_ff <= 8'h00;
        end else if (core_tick_ff) begin
            stable_cnt_ff <= stable_cnt_ff + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            pc_load_ff <= 1'b0;
        end else begin
            pc_load_ff <= wake;
        end
    end

    // ****************************************
    // core and IR clock enables
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (blk_rst || state_ff == ST_HALT) begin
            core_cnt_ff <= 8'h00;
            core_tick_ff <= 1'b0;
        end else if (core_cnt_ff == 8'h00) begin
            core_cnt_ff <= core_div_cyc({core_clock_select_hi_i, core_clock_select_lo_i},
                                        crystal_mode_option_n_i) - 8'h01;
            core_tick_ff <= 1'b1;
        end else begin
            core_cnt_ff <= core_cnt_ff - 8'h01;
            core_tick_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst || state_ff == ST_HALT) begin
            ir_cnt_ff <= 3'h0;
            ir_tick_ff <= 1'b0;
        end else if (ir_cnt_ff == 3'h0) begin
            ir_cnt_ff <= xtal_mode ? IR_LAST_XT : IR_LAST_RC;
            ir_tick_ff <= 1'b1;
        end else begin
            ir_cnt_ff <= ir_cnt_ff - 3'h1;
            ir_tick_ff <= 1'b0;
        end
    end

    rkp_ir_gen u_ir (
        .ref_clk_i(ref_clk_i),
        .rst_i(blk_rst),
        .tick_i(ir_tick_ff),
        .code_i(ir_ctl_ff[2:0]),
        .static_i(ir_ctl_ff[IR_STATIC_BIT]),
        .level_o(ir_level)
    );

    // ****************************************
    // register writes
    // ****************************************
    assign wr_main = reg_wr_i & ~reg_ext_i;
    assign wr_ext = reg_wr_i & reg_ext_i & ~reg_addr_i[4];

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            pa_dir_ff <= REG_RST;
            pb_dir_ff <= REG_RST;
            pd_dir_ff <= REG_RST;
            pa_dat_ff <= 3'h0;
            pb_dat_ff <= REG_RST;
            pd_dat_ff <= REG_RST;
            pc_ctl_ff <= REG_RST;
            ir_ctl_ff <= REG_RST;
        end else if (wr_main) begin
            unique case (reg_addr_i)
                ADR_PA_DIR: pa_dir_ff <= reg_wdata_i;
                ADR_PA_DAT: pa_dat_ff <= reg_wdata_i[2:0];
                ADR_PC_CTL: pc_ctl_ff <= reg_wdata_i;
                ADR_PB_DIR: pb_dir_ff <= reg_wdata_i;
                ADR_PB_DAT: pb_dat_ff <= reg_wdata_i;
                ADR_PD_DIR: pd_dir_ff <= reg_wdata_i;
                ADR_PD_DAT: pd_dat_ff <= reg_wdata_i;
                ADR_IR_CTL: ir_ctl_ff <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            pa_pu_ff <= REG_RST;
            pb_pu_ff <= REG_RST;
            pd_pu_ff <= REG_RST;
            pa_wk_ff <= REG_RST;
            pb_wk_ff <= REG_RST;
            pd_wk_ff <= REG_RST;
        end else if (wr_ext) begin
            unique case (reg_addr_i[3:0])
                XADR_PA_PU: pa_pu_ff <= reg_wdata_i;
                XADR_PB_PU: pb_pu_ff <= reg_wdata_i;
                XADR_PD_PU: pd_pu_ff <= reg_wdata_i;
                XADR_PA_WK: pa_wk_ff <= reg_wdata_i;
                XADR_PB_WK: pb_wk_ff <= reg_wdata_i;
                XADR_PD_WK: pd_wk_ff <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // ****************************************
    // register reads, one cycle late
    // ****************************************
    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            rdata_ff <= 4'h0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_i;
            rdata_ff <= 4'h0;
            // extended space is write only and reads as zero
            if (reg_rd_i && !reg_ext_i) begin
                unique case (reg_addr_i)
                    ADR_PA_DIR: rdata_ff <= pa_dir_ff;
                    ADR_PA_DAT: rdata_ff <= rd_mix({1'b0, pa_dir_ff[2:0]},
                                                   {1'b0, pa_dat_ff}, pa_in_i);
                    ADR_PC_CTL: rdata_ff <= {pc_ctl_ff[3:1], pc_ctl_ff[PC_DIR_BIT] ?
                                            pc_ctl_ff[PC_DAT_BIT] : pc_in_i};
                    ADR_PB_DIR: rdata_ff <= pb_dir_ff;
                    ADR_PB_DAT: rdata_ff <= rd_mix(pb_dir_ff, pb_dat_ff, pb_in_i);
                    ADR_PD_DIR: rdata_ff <= pd_dir_ff;
                    ADR_PD_DAT: rdata_ff <= rd_mix(pd_dir_ff, pd_dat_ff, pd_in_i);
                    ADR_IR_CTL: rdata_ff <= ir_ctl_ff;
                    default: rdata_ff <= 4'h0;
                endcase
            end
        end
    end

    // ****************************************
    // pin configuration in scan order
    // ****************************************
    // crystal pins PB1/PB0 sit at scan indices 6 and 5
    assign xmask_v = xtal_mode ? 12'h060 : 12'h000;
    assign dir_v = scan_vec(pa_dir_ff, pb_dir_ff, pd_dir_ff, pc_ctl_ff[PC_DIR_BIT]) & ~xmask_v;
    assign dat_v = scan_vec({1'b0, pa_dat_ff}, pb_dat_ff, pd_dat_ff, pc_ctl_ff[PC_DAT_BIT]);
    assign pu_v = scan_vec(pa_pu_ff, pb_pu_ff, pd_pu_ff, pc_ctl_ff[PC_PU_BIT]) & ~xmask_v;
    assign wk_v = scan_vec(pa_wk_ff, pb_wk_ff, pd_wk_ff, pc_ctl_ff[PC_WK_BIT]) & ~xmask_v;
    assign scan_v = scanning ? wk_v : 12'h000;

    always_comb begin
        oe_v = dir_v;
        out_v = dat_v;
        pul_v = pu_v & ~dir_v;
        // scanned pins are inputs with pull-up except the one being pulsed
        oe_v = (oe_v & ~scan_v) | (scan_v & drive_ff);
        out_v = out_v & ~(scan_v & drive_ff);
        pul_v = (pul_v & ~scan_v) | (scan_v & ~drive_ff);
    end

    assign {pa_oe_o[2:0], pb_oe_o, pd_oe_o, pc_oe_o} = oe_v;
    assign {pa_out_o[2:0], pb_out_o, pd_out_o, pc_out_o} = out_v;
    assign {pa_pu_o[2:0], pb_pu_o, pd_pu_o, pc_pu_o} = pul_v;
    assign pa_oe_o[3] = 1'b0;
    assign pa_out_o[3] = 1'b0;
    assign pa_pu_o[3] = pa_pu_ff[3] & pa3_io;

    // ****************************************
    // halt key scan
    // ****************************************
    assign scanning = (state_ff == ST_HALT) & key_scan_option_i;
    assign ks_tick = (ks_cnt_ff == KS_LAST);

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst || !scanning) begin
            ks_cnt_ff <= 11'h000;
            sub_ff <= 2'h0;
            slot_ff <= 4'h0;
        end else begin
            ks_cnt_ff <= ks_tick ? 11'h000 : ks_cnt_ff + 11'h001;
            if (ks_tick) begin
                sub_ff <= (sub_ff == SUB_LAST) ? 2'h0 : sub_ff + 2'h1;
                if (sub_ff == SUB_LAST) begin
                    // fixed slot count keeps the period constant
                    slot_ff <= (slot_ff == SLOT_LAST) ? 4'h0 : slot_ff + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst || !scanning) begin
            drive_ff <= 12'h000;
            drive_prev_ff <= 12'h000;
        end else begin
            drive_prev_ff <= drive_ff;
            if (slot_ff < SLOT_PINS && sub_ff == 2'h1) begin
                drive_ff <= (12'h800 >> slot_ff) & wk_v;
            end else begin
                drive_ff <= 12'h000;
            end
        end
    end

    // ****************************************
    // edge wake detection
    // ****************************************
    assign lvl_v = {pa_in_i[3], scan_vec(pa_in_i, pb_in_i, pd_in_i, pc_in_i)};
    assign wke_v = {pa_wk_ff[3] & pa3_io, wk_v};
    // a pin's own pulse is not a key press
    assign edge_v = (lvl_v ^ prev_ff) & wke_v & ~{1'b0, drive_ff | drive_prev_ff};
    assign wake = (state_ff == ST_HALT) & (|edge_v);

    always_ff @(posedge ref_clk_i) begin
        if (blk_rst) begin
            prev_ff <= 13'h0000;
        end else begin
            prev_ff <= lvl_v;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata_o = rdata_ff;
    assign reg_rvalid_o = rvalid_ff;
    assign ir_led_output_pin_o = 1'b0;
    assign ir_led_output_pin_oe_o = ~ir_level;
    assign sys_reset_o = sys_reset_ff;
    assign low_voltage_reset_en_o = lv_en_ff;
    assign osc_run_o = (state_ff != ST_HALT);
    assign crystal_osc_en_o = xtal_mode;
    assign core_clk_en_o = core_tick_ff;
    assign core_run_o = (state_ff == ST_RUN);
    assign pc_load_o = pc_load_ff;
    assign pc_load_addr_o = WAKE_VECTOR;
endmodule

/* File: bench/rkp_ports_checker.sv */
// assertions bound into the port block
`timescale 1ns/100ps
module rkp_ports_checker
    import rkp_pkg::*;
(
    input wire logic ref_clk_i, rst_i, reg_ext_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
    input wire logic ir_led_output_pin_o, wdt_overflow_i, halt_req_i, sys_reset_o,
    input wire logic low_voltage_reset_en_o, osc_run_o, core_run_o, pc_load_o,
    input wire logic [4:0] reg_addr_i,
    input wire logic [3:0] reg_wdata_i, pa_oe_o, pa_pu_o
);
    default clocking @(posedge ref_clk_i); endclocking
    // block reset outlasts rst_i by one edge
    default disable iff (rst_i || sys_reset_o);
    pa3_input_a: assert property (pa_oe_o[3] == 1'b0)
        else $error("input-only pin driven");
    pullup_drive_a: assert property ((pa_oe_o & pa_pu_o) == 4'h0)
        else $error("pull-up on while driving");
    read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read not answered");
    rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
        else $error("answer without read");
    dir_write_a: assert property (core_run_o && reg_wr_i && !reg_ext_i
        && reg_addr_i == ADR_PA_DIR |=> pa_oe_o[2:0] == $past(reg_wdata_i[2:0]))
        else $error("direction write not applied");
    reset_merge_a: assert property (disable iff (rst_i) wdt_overflow_i |=> sys_reset_o)
        else $error("watchdog reset lost");
    halt_stop_a: assert property (halt_req_i && core_run_o
        |-> ##2 !osc_run_o && !low_voltage_reset_en_o)
        else $error("halt left clock running");
    wake_settle_a: assert property (pc_load_o |-> !core_run_o [*8])
        else $error("ran before settle");
    ir_sink_a: assert property (ir_led_output_pin_o == 1'b0)
        else $error("ir pin driven high");
endmodule
bind rkp_ports rkp_ports_checker i_rkp_ports_checker (.*);

/* File: bench/rkp_key_model.sv */
// key switches to ground, pull-ups and floating pins
`timescale 1ns/100ps
module rkp_key_model (
    input wire logic clk_i,
    input wire logic [12:0] out_i, oe_i, pu_i, key_i,
    output logic [12:0] lvl_o
);
    // floating pin: inverse of its last level
    logic [12:0] last_ff = '0;
    always_ff @(posedge clk_i) begin
        last_ff <= lvl_o;
    end
    assign lvl_o = (oe_i & out_i) | (~oe_i & ~key_i & (pu_i | ~last_ff));
endmodule

/* File: bench/rkp_ports_tb.sv */
// self-checking bench for the remote-control port block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
`define WAITC(c) begin for (n = 0; n < 70000 && !(c); n++) @(negedge ref_clk_i); \
    if (!(c)) begin err_total++; give_verdict; end end
`define LEN(c) for (n = 0; n < 2000 && (c); n++) @(negedge ref_clk_i);
module rkp_ports_tb import rkp_pkg::*; ;
    localparam int STB = 4;
    logic ref_clk_i = 0, rst_i = 1, reg_ext_i = 0, reg_wr_i = 0, reg_rd_i = 0, halt_req_i = 0;
    logic key_scan_option_i = 0, crystal_mode_option_n_i = 1, core_clock_select_hi_i = 1;
    logic core_clock_select_lo_i = 1, shared_reset_pin_option_i = 1, por_i = 0, lv_detect_i = 0;
    logic wdt_overflow_i = 0, reg_rvalid_o, pc_in_i, pc_out_o, pc_oe_o, pc_pu_o, sys_reset_o;
    logic ir_led_output_pin_o, ir_led_output_pin_oe_o, low_voltage_reset_en_o, osc_run_o;
    logic crystal_osc_en_o, core_clk_en_o, core_run_o, pc_load_o;
    logic [4:0] reg_addr_i = '0;
    logic [3:0] reg_wdata_i = '0, reg_rdata_o, pa_in_i, pa_out_o, pa_oe_o, pa_pu_o, pb_in_i;
    logic [3:0] pb_out_o, pb_oe_o, pb_pu_o, pd_in_i, pd_out_o, pd_oe_o, pd_pu_o;
    logic [10:0] pc_load_addr_o;
    // key bits: 12..9 port A, 8..5 port B, 4..1 port D, 0 PC0
    logic [12:0] key = '0;
    int err_total = 0, tests_run = 0, n, m;
    wire ir_oe = ir_led_output_pin_oe_o;
    rkp_ports #(.STABLE_CYCLES(STB)) i_rkp_ports (.*);
    rkp_key_model i_rkp_key_model (.clk_i(ref_clk_i), .key_i(key),
        .out_i({pa_out_o, pb_out_o, pd_out_o, pc_out_o}),
        .oe_i({pa_oe_o, pb_oe_o, pd_oe_o, pc_oe_o}), .pu_i({pa_pu_o, pb_pu_o, pd_pu_o, pc_pu_o}),
        .lvl_o({pa_in_i, pb_in_i, pd_in_i, pc_in_i}));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic x, input logic [4:0] a, input logic [3:0] d);
        @(negedge ref_clk_i);
        reg_ext_i = x;
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(negedge ref_clk_i);
        reg_wr_i = 0;
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [3:0] e);
        @(negedge ref_clk_i);
        reg_ext_i = 0;
        reg_addr_i = a;
        reg_rd_i = 1;
        @(negedge ref_clk_i);
        reg_rd_i = 0;
        `CHK({reg_rvalid_o, reg_rdata_o}, {1'b1, e})
    endtask
    task automatic do_halt;
        @(negedge ref_clk_i);
        halt_req_i = 1;
        @(negedge ref_clk_i);
        halt_req_i = 0;
    endtask
    task automatic t_ports;
        wr_reg(1, {1'b0, XADR_PB_PU}, 4'hf);
        wr_reg(0, ADR_PB_DAT, 4'h3);
        wr_reg(0, ADR_PB_DIR, 4'h5);
        `CHK({pb_oe_o, pb_out_o & 4'h5, pb_pu_o}, 12'h51a)
        rd_chk(ADR_PB_DAT, 4'hb);
        key[8] = 1;
        rd_chk(ADR_PB_DAT, 4'h3);
        key[8] = 0;
        wr_reg(0, ADR_PA_DAT, 4'hf);
        wr_reg(0, ADR_PA_DIR, 4'hf);
        `CHK({pa_oe_o, pa_out_o}, 8'h77)
        wr_reg(0, ADR_PC_CTL, 4'hb);
        `CHK({pc_oe_o, pc_pu_o, pc_out_o}, 3'b101)
        rd_chk(ADR_PC_CTL, 4'hb);
        $display("port access test done");
    endtask
    task automatic t_ir;
        for (int i = 0; i < 2; i++) begin
            wr_reg(0, ADR_IR_CTL, {i[0], 3'b000});
            repeat (3) @(negedge ref_clk_i);
            `CHK(ir_oe, !i[0])
        end
        // measure from a fresh low edge
        for (int i = 1; i < 8; i++) begin
            wr_reg(0, ADR_IR_CTL, 4'(i));
            `WAITC(ir_oe === 1'b0)
            `WAITC(ir_oe === 1'b1)
            `LEN(ir_oe === 1'b1)
            `CHK(n, IR_LOW[i] * IR_CYC_RC)
            `LEN(ir_oe === 1'b0)
            `CHK(n, (IR_PERIOD[i] - IR_LOW[i]) * IR_CYC_RC)
        end
        $display("ir carrier test done");
    endtask
    task automatic t_wake;
        wr_reg(1, {1'b0, XADR_PD_PU}, 4'hf);
        wr_reg(1, {1'b0, XADR_PD_WK}, 4'h1);
        do_halt;
        @(negedge ref_clk_i);
        `CHK({osc_run_o, low_voltage_reset_en_o, core_run_o}, 3'b000)
        key[2] = 1;
        repeat (20) @(negedge ref_clk_i);
        `CHK({osc_run_o, core_run_o}, 2'b00)
        key[1] = 1;
        `WAITC(pc_load_o === 1'b1)
        `CHK(pc_load_addr_o, 11'h004)
        m = 0;
        for (n = 0; n < 2000 && core_run_o !== 1'b1; n++) begin
            @(negedge ref_clk_i);
            m += int'(core_clk_en_o === 1'b1);
        end
        `CHK(m, STB)
        key = '0;
        $display("halt wake test done");
    endtask
    task automatic t_scan;
        wr_reg(0, ADR_PA_DIR, 4'h0);
        wr_reg(1, {1'b0, XADR_PA_PU}, 4'h4);
        wr_reg(1, {1'b0, XADR_PA_WK}, 4'h4);
        wr_reg(0, ADR_PD_DIR, 4'h2);
        key_scan_option_i = 1;
        do_halt;
        `WAITC(pa_oe_o[2] === 1'b1)
        `CHK({pa_out_o[2], pa_pu_o[2], pd_oe_o}, 6'h02)
        `LEN(pa_oe_o[2] === 1'b1)
        `CHK(n, KS_TICK_CYC)
        // press well clear of the pin's own pulse
        repeat (3000) @(negedge ref_clk_i);
        key[11] = 1;
        `WAITC(core_run_o === 1'b1)
        `CHK({pa_oe_o[2], pa_pu_o[2], pd_oe_o}, 6'h12)
        key = '0;
        $display("key scan test done");
    endtask
    initial begin
        repeat (5) @(negedge ref_clk_i);
        rst_i = 0;
        `WAITC(core_run_o === 1'b1)
        `CHK({pa_oe_o, pb_oe_o, pd_oe_o}, 12'h000)
        t_ports;
        t_ir;
        t_wake;
        t_scan;
        @(negedge ref_clk_i);
        wdt_overflow_i = 1;
        @(negedge ref_clk_i);
        wdt_overflow_i = 0;
        `WAITC(core_run_o === 1'b0)
        `WAITC(core_run_o === 1'b1)
        `CHK(pb_oe_o, 4'h0)
        $display("reset source test done");
        give_verdict;
    end
endmodule
